// ---- adcrc_regs.svh ----
// register map, field positions and timing counts of the result coder
// What this block does
// [R1] saturation on: out-of-range result forced to extremes
// [R2] saturation off: code wraps (unipolar below range gives zero), flags decode it
// [R3] overrange flag derived digitally from result only
// [R4] bipolar codes, sign flag, wrap above full scale
// [R5] bipolar below range wraps down, both flags set
// [R6] unipolar codes, wrap above, zero below range
// [R7] chopping: reversed second conversion, results averaged
// [R8] chop: 42-cycle settle, then 163-cycle scaling
// [R9] no chopping: single sample, no reversal, no average
`ifndef ADCRC_REGS_SVH
`define ADCRC_REGS_SVH

// ============================================================
// register offsets
`define ADCRC_CTRL_OFS      8'h00
`define ADCRC_DATA_OFS      8'h04
`define ADCRC_CHSTAT_OFS    8'h08
`define ADCRC_IRQ_STAT_OFS  8'h0C
`define ADCRC_IRQ_MASK_OFS  8'h10

// ============================================================
// control fields
`define ADCRC_CTRL_SAT_BIT    0
`define ADCRC_CTRL_CHOP_BIT   1
`define ADCRC_CTRL_BIP_BIT    2
`define ADCRC_CTRL_START_BIT  3
`define ADCRC_CTRL_RESET      3'h0

// channel status fields
`define ADCRC_CHS_SIGN_BIT  0
`define ADCRC_CHS_OVR_BIT   1
`define ADCRC_CHS_BUSY_BIT  2

// interrupt status fields
`define ADCRC_IRQ_DONE_BIT  0
`define ADCRC_IRQ_OVR_BIT   1
`define ADCRC_IRQ_WIDTH     2

// ============================================================
// timing in master clock cycles
`define ADCRC_SETTLE1_CYC  8'h2B
`define ADCRC_SETTLE2_CYC  8'h2A
`define ADCRC_SCALE_CYC    8'hA3

// ============================================================
// code limits
`define ADCRC_CODE_MAX   16'hFFFF
`define ADCRC_CODE_MIN   16'h0000
`define ADCRC_BIP_OFFS   16'h8000

`endif

// ---- adcrc_pkg.sv ----
// types shared by the result coder modules
package adcrc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SETTLE1 = 3'b001,
    ST_SAMPLE1 = 3'b010,
    ST_SETTLE2 = 3'b011,
    ST_SAMPLE2 = 3'b100,
    ST_SCALE   = 3'b101
  } adcrc_state_type;

  typedef logic signed [20:0] adcrc_value_type;

endpackage : adcrc_pkg

// ---- adcrc_fmt_if.sv ----
// carrier between the sequencer and the code formatter
`timescale 1ns/1ps
interface adcrc_fmt_if;
  import adcrc_pkg::*;
  logic            load;
  adcrc_value_type value;
  logic            bipolar;
  logic            saturate;
  logic [15:0]     code;
  logic            sign;
  logic            overrange_flag;

  modport seq (output load, value, bipolar, saturate,
               input code, sign, overrange_flag);
  modport fmt (input load, value, bipolar, saturate,
               output code, sign, overrange_flag);
endinterface : adcrc_fmt_if

// ---- adcrc_format.sv ----
// code formatter: range decode, wrap or saturate, sign and overrange
`timescale 1ns/1ps
`include "adcrc_regs.svh"
module adcrc_format
  import adcrc_pkg::*;
(
  // clock, reset and enable
  input  wire logic  clk,
  input  wire logic  rst_b,
  input  wire logic  ce,
  // formatter side
  adcrc_fmt_if.fmt   fi
);

  // ============================================================
  // range decode
  function automatic logic above_range(adcrc_value_type v, logic bip);
    above_range = bip ? (v > 21'sd32767) : (v > 21'sd65535);
  endfunction : above_range

  function automatic logic below_range(adcrc_value_type v, logic bip);
    below_range = bip ? (v < -21'sd32768) : (v < 21'sd0);
  endfunction : below_range

  logic        over_hi;
  logic        over_lo;
  logic [15:0] wrap_code;
  logic [15:0] next_code;
  logic        next_sign;

  always_comb begin
    over_hi   = above_range(fi.value, fi.bipolar);
    over_lo   = below_range(fi.value, fi.bipolar);
    wrap_code = fi.bipolar ? fi.value[15:0] + `ADCRC_BIP_OFFS
                           : fi.value[15:0];
    next_sign = fi.value < 21'sd0;                       // [R4] [R5] [R6]
    if (fi.saturate && over_hi) begin
      next_code = `ADCRC_CODE_MAX;                       // [R1]
    end else if (fi.saturate && over_lo) begin
      next_code = `ADCRC_CODE_MIN;                       // [R1]
    end else if (!fi.bipolar && over_lo) begin
      next_code = `ADCRC_CODE_MIN;                       // [R6]
    end else begin
      next_code = wrap_code;                             // [R2] [R4] [R5]
    end
  end

  // ============================================================
  // data and status registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fi.code <= 16'h0000;
      fi.sign <= 1'b0;
      fi.overrange_flag  <= 1'b0;
    end else if (ce && fi.load) begin
      fi.code <= next_code;
      fi.sign <= next_sign;
      fi.overrange_flag  <= over_hi || over_lo;                     // [R3]
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_load_sat;
    ce && fi.load && fi.saturate;
  endsequence

  a_sat_high_code: assert property (                     // [R1]
    s_load_sat ##0 over_hi |=> fi.code == 16'hFFFF && fi.overrange_flag)
    else $error("saturated high code is not all ones");
  a_sat_low_code: assert property (                      // [R1]
    s_load_sat ##0 over_lo |=> fi.code == 16'h0000 && fi.overrange_flag)
    else $error("saturated low code is not all zeros");
  a_ovr_from_value: assert property (                    // [R3]
    ce && fi.load |=> fi.overrange_flag == ($past(fi.bipolar)
      ? ($past(fi.value) > 21'sd32767 || $past(fi.value) < -21'sd32768)
      : ($past(fi.value) > 21'sd65535 || $past(fi.value) < 21'sd0)))
    else $error("overrange flag does not follow the result");
  a_bip_above_wrap: assert property (                    // [R4]
    ce && fi.load && !fi.saturate && fi.bipolar
      && fi.value > 21'sd32767
    |=> fi.code == $past(fi.value[15:0]) - 16'h8000
      && !fi.sign && fi.overrange_flag)
    else $error("bipolar wrap above full scale wrong");
  a_bip_below_wrap: assert property (                    // [R5]
    ce && fi.load && !fi.saturate && fi.bipolar
      && fi.value < -21'sd32768
    |=> fi.sign && fi.overrange_flag
      && fi.code == $past(fi.value[15:0]) + 16'h8000)
    else $error("bipolar wrap below full scale wrong");
  a_uni_below_zero: assert property (                    // [R6]
    ce && fi.load && !fi.bipolar && fi.value < 21'sd0
    |=> fi.code == 16'h0000 && fi.sign && fi.overrange_flag)
    else $error("unipolar negative result not coded as zero");

endmodule : adcrc_format

// ---- adcrc_core.sv ----
// result coder top: APB registers, chop sequencer, interrupt
`timescale 1ns/1ps
`include "adcrc_regs.svh"
module adcrc_core
  import adcrc_pkg::*;
(
  // clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        CE,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // modulator and filter
  input  wire logic        MOD_VALID,
  input  wire logic [19:0] MOD_RESULT,
  output logic             MOD_RUN,
  output logic             CHOP_REVERSE,
  // interrupt
  output logic             IRQ
);

  adcrc_fmt_if fi ();

  adcrc_format u_format (
    .clk   (CLK),
    .rst_b (RST_B),
    .ce    (CE),
    .fi    (fi.fmt)
  );

  // ============================================================
  // bus decode
  adcrc_state_type state;
  adcrc_state_type next_state;
  logic [7:0]      cnt;
  logic [2:0]      ctrl;
  logic            start_req;
  logic [1:0]      irq_stat;
  logic [1:0]      irq_mask;
  logic            wr_en;
  logic            rd_en;
  logic            hit;
  logic signed [19:0] first_res;
  logic            done_evt;

  function automatic logic addr_hit(logic [7:0] a, logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  always_comb begin
    hit = addr_hit(PADDR, `ADCRC_CTRL_OFS)
       || addr_hit(PADDR, `ADCRC_DATA_OFS)
       || addr_hit(PADDR, `ADCRC_CHSTAT_OFS)
       || addr_hit(PADDR, `ADCRC_IRQ_STAT_OFS)
       || addr_hit(PADDR, `ADCRC_IRQ_MASK_OFS);
    wr_en = CE && PSEL && PENABLE && PWRITE && hit;
    rd_en = PSEL && PENABLE && !PWRITE;
  end

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;

  // ============================================================
  // control register
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ctrl <= `ADCRC_CTRL_RESET;
    end else if (wr_en && addr_hit(PADDR, `ADCRC_CTRL_OFS)) begin
      ctrl <= PWDATA[2:0];
    end
  end

  always_comb begin
    start_req = wr_en && addr_hit(PADDR, `ADCRC_CTRL_OFS)
             && PWDATA[`ADCRC_CTRL_START_BIT] && state == ST_IDLE;
  end

  // ============================================================
  // conversion sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_req) begin
          next_state = ST_SETTLE1;
        end
      end
      ST_SETTLE1: begin
        if (cnt == 8'h00) begin
          next_state = ST_SAMPLE1;
        end
      end
      ST_SAMPLE1: begin
        if (MOD_VALID) begin
          next_state = ctrl[`ADCRC_CTRL_CHOP_BIT] ? ST_SETTLE2  // [R7]
                                                  : ST_SCALE;   // [R9]
        end
      end
      ST_SETTLE2: begin
        if (cnt == 8'h00) begin
          next_state = ST_SAMPLE2;                              // [R8]
        end
      end
      ST_SAMPLE2: begin
        if (MOD_VALID) begin
          next_state = ST_SCALE;                                // [R7]
        end
      end
      ST_SCALE: begin
        if (cnt == 8'h00) begin
          next_state = ST_IDLE;                                 // [R8]
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state <= ST_IDLE;
    end else if (CE) begin
      state <= next_state;
    end
  end

  // phase length counter, loaded with length minus one on entry
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      cnt <= 8'h00;
    end else if (CE) begin
      if (state == ST_IDLE && start_req) begin
        cnt <= `ADCRC_SETTLE1_CYC - 8'h01;
      end else if (state == ST_SAMPLE1 && next_state == ST_SETTLE2) begin
        cnt <= `ADCRC_SETTLE2_CYC - 8'h01;                      // [R8]
      end else if (next_state == ST_SCALE && state != ST_SCALE) begin
        cnt <= `ADCRC_SCALE_CYC - 8'h01;                        // [R8]
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end

  // ============================================================
  // sample capture and averaging
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      first_res <= 20'sh0_0000;
    end else if (CE && state == ST_SAMPLE1 && MOD_VALID) begin
      first_res <= MOD_RESULT;
    end
  end

  // reversed second sample carries the negated signal: halve the difference
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      fi.value <= '0;
    end else if (CE && state == ST_SAMPLE2 && MOD_VALID) begin
      fi.value <= (adcrc_value_type'(first_res)
                 - adcrc_value_type'($signed(MOD_RESULT))) >>> 1; // [R7]
    end else if (CE && state == ST_SAMPLE1 && MOD_VALID
                 && !ctrl[`ADCRC_CTRL_CHOP_BIT]) begin
      fi.value <= adcrc_value_type'($signed(MOD_RESULT));       // [R9]
    end
  end

  always_comb begin
    done_evt    = CE && state == ST_SCALE && cnt == 8'h00;
    fi.load     = done_evt;
    fi.bipolar  = ctrl[`ADCRC_CTRL_BIP_BIT];
    fi.saturate = ctrl[`ADCRC_CTRL_SAT_BIT];                    // [R1] [R2]
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      MOD_RUN      <= 1'b0;
      CHOP_REVERSE <= 1'b0;
    end else if (CE) begin
      MOD_RUN      <= next_state == ST_SAMPLE1
                   || next_state == ST_SAMPLE2;
      CHOP_REVERSE <= next_state == ST_SETTLE2
                   || next_state == ST_SAMPLE2;                 // [R7] [R9]
    end
  end

  // ============================================================
  // interrupt status, mask and output
  logic [1:0] irq_set;

  always_comb begin
    irq_set[`ADCRC_IRQ_DONE_BIT] = done_evt;
    irq_set[`ADCRC_IRQ_OVR_BIT]  = 1'b0;
  end

  // overrange event seen one cycle after the formatter has loaded
  logic load_d;
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      load_d <= 1'b0;
    end else if (CE) begin
      load_d <= done_evt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `ADCRC_IRQ_WIDTH; gi = gi + 1) begin : g_irq
      logic ev;
      assign ev = (gi == `ADCRC_IRQ_OVR_BIT) ? (load_d && fi.overrange_flag)
                                             : irq_set[gi];
      // a set in the clearing cycle wins
      always_ff @(posedge CLK) begin
        if (!RST_B) begin
          irq_stat[gi] <= 1'b0;
        end else if (CE && ev) begin
          irq_stat[gi] <= 1'b1;
        end else if (wr_en && addr_hit(PADDR, `ADCRC_IRQ_STAT_OFS)
                     && PWDATA[gi]) begin
          irq_stat[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      irq_mask <= 2'h0;
    end else if (wr_en && addr_hit(PADDR, `ADCRC_IRQ_MASK_OFS)) begin
      irq_mask <= PWDATA[1:0];
    end
  end

  assign IRQ = |(irq_stat & irq_mask);

  // ============================================================
  // read mux
  always_comb begin
    PRDATA = 32'h0000_0000;
    if (rd_en) begin
      case (PADDR)
        `ADCRC_CTRL_OFS:     PRDATA = {29'h0000_0000, ctrl};
        `ADCRC_DATA_OFS:     PRDATA = {16'h0000, fi.code};
        `ADCRC_CHSTAT_OFS:   PRDATA = {29'h0000_0000,
                                       state != ST_IDLE, fi.overrange_flag,
                                       fi.sign};                // [R2]
        `ADCRC_IRQ_STAT_OFS: PRDATA = {30'h0000_0000, irq_stat};
        `ADCRC_IRQ_MASK_OFS: PRDATA = {30'h0000_0000, irq_mask};
        default:             PRDATA = 32'h0000_0000;
      endcase
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_first_taken;
    CE && state == ST_SAMPLE1 && MOD_VALID;
  endsequence

  sequence s_settle2_over;
    CE && state == ST_SETTLE2 && cnt == 8'h00;
  endsequence

  a_chop_second_settle: assert property (                // [R8]
    s_first_taken ##0 ctrl[1]
    |=> state == ST_SETTLE2 && cnt == 8'h29 && CHOP_REVERSE)
    else $error("chop settle does not start with 42 cycles");
  a_nochop_to_scale: assert property (                   // [R9]
    s_first_taken ##0 !ctrl[1]
    |=> state == ST_SCALE && cnt == 8'hA2 && !CHOP_REVERSE)
    else $error("unchopped result did not go to scaling");
  a_reverse_sample: assert property (                    // [R7]
    s_settle2_over |=> state == ST_SAMPLE2 && MOD_RUN && CHOP_REVERSE)
    else $error("second sample not taken reversed");
  a_average_value: assert property (                     // [R7]
    CE && state == ST_SAMPLE2 && MOD_VALID
    |=> fi.value == (adcrc_value_type'($past(first_res))
       - adcrc_value_type'($signed($past(MOD_RESULT)))) >>> 1)
    else $error("chopped result is not the average");
  a_scale_done_irq: assert property (                    // [R8]
    CE && state == ST_SCALE && cnt == 8'h00
    |=> state == ST_IDLE && irq_stat[0])
    else $error("scaling end did not post the result");

endmodule : adcrc_core

// ---- adcrc_mod_model.sv ----
// modulator and filter stand-in that answers each sample phase
`timescale 1ns/1ps
module adcrc_mod_model (
  // clock
  input  wire logic        clk,
  // sequencer side
  input  wire logic        mod_run,
  input  wire logic        chop_reverse,
  output logic             mod_valid,
  output logic [19:0]      mod_result,
  // results handed back and answer delay
  input  wire logic [19:0] first,
  input  wire logic [19:0] second,
  input  wire logic [3:0]  delay
);
  logic [3:0] cnt;

  initial begin
    mod_valid  = 1'b0;
    mod_result = 20'h0_0000;
    cnt        = 4'h0;
  end

  // ==========================================================
  // answer after delay cycles of a sample phase
  always @(posedge clk) begin
    mod_valid <= 1'b0;
    if (mod_run && !mod_valid && cnt == delay) begin
      mod_valid  <= 1'b1;
      mod_result <= chop_reverse ? second : first;
      cnt        <= 4'h0;
    end else begin
      // result bus is inverted every cycle outside the pulse, so it never holds steady
      mod_result <= ~mod_result;
      cnt        <= (mod_run && !mod_valid) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : adcrc_mod_model

// ---- adc_result_range_coding_bench.sv ----
// self-checking bench for the result coder
`timescale 1ns/1ps
`include "adcrc_regs.svh"
module adc_result_range_coding_bench;
  typedef struct {
    logic [2:0]  mode;
    logic [19:0] first;
    logic [19:0] second;
    logic [15:0] code;
    logic        sgn;
    logic        overrange_flag;
  } adcrc_row_type;

  logic        CLK = 0, RST_B = 0, CE = 1;
  logic        PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA, rdata;
  logic        PREADY, PSLVERR, rerr, IRQ;
  logic        MOD_VALID, MOD_RUN, CHOP_REVERSE, run_q = 0;
  logic [19:0] MOD_RESULT, first = 0, second = 0;
  logic [3:0]  delay = 0;
  logic [31:0] since_valid = 0;
  int          runs = 0, settle = 0, failures = 0, compares = 0;
  adcrc_row_type rows [20];

  always #10 CLK = ~CLK;

  adcrc_core dut (.CLK(CLK), .RST_B(RST_B), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .MOD_VALID(MOD_VALID), .MOD_RESULT(MOD_RESULT), .MOD_RUN(MOD_RUN),
    .CHOP_REVERSE(CHOP_REVERSE), .IRQ(IRQ));

  adcrc_mod_model model (.clk(CLK), .mod_run(MOD_RUN),
    .chop_reverse(CHOP_REVERSE), .mod_valid(MOD_VALID),
    .mod_result(MOD_RESULT), .first(first), .second(second),
    .delay(delay));

  // ==========================================================
  // phase counters
  always @(posedge CLK) begin
    since_valid <= MOD_VALID ? 32'h0000_0000 : since_valid + 1;
    run_q       <= MOD_RUN;
    if (MOD_RUN && !run_q) runs <= runs + 1;
    if (CHOP_REVERSE && !MOD_RUN) settle <= settle + 1;
  end

  // ==========================================================
  // tasks
  task report_and_stop;
    begin
      if (failures == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask : report_and_stop

  task chk(input string nm, input logic [31:0] seen, exp);
    begin
      compares++;
      if (seen !== exp) begin
        failures++;
        $display("Error %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge CLK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= w;
      PADDR   <= a;
      PWDATA  <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
        @(posedge CLK);
        n++;
      end while (PREADY !== 1'b1 && n < 20);
      rdata = PRDATA;
      rerr = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
      if (n >= 20) begin
        failures++;
        report_and_stop();
      end
      #1;
    end
  endtask : apb

  task conv(input adcrc_row_type r, input logic [3:0] dl);
    int r0, s0, n;
    begin
      first  <= r.first;
      second <= r.second;
      delay  <= dl;
      r0 = runs;
      s0 = settle;
      apb(1'b1, `ADCRC_IRQ_MASK_OFS, 32'h0000_0001);
      apb(1'b1, `ADCRC_CTRL_OFS, {28'h000_0000, 1'b1, r.mode});
      n = 0;
      while (IRQ !== 1'b1 && n < 5000) begin
        @(posedge CLK);
        #1;
        n++;
      end
      if (n >= 5000) begin
        failures++;
        report_and_stop();
      end
      chk("scale", since_valid, 32'h0000_00A3);
      apb(1'b0, `ADCRC_DATA_OFS, 32'h0000_0000);
      chk("data", rdata, {16'h0000, r.code});
      apb(1'b0, `ADCRC_CHSTAT_OFS, 32'h0000_0000);
      chk("status", rdata, {29'h0, 1'b0, r.overrange_flag, r.sgn});
      apb(1'b0, `ADCRC_IRQ_STAT_OFS, 32'h0000_0000);
      chk("irq_stat", rdata, {30'h0, r.overrange_flag, 1'b1});
      apb(1'b1, `ADCRC_IRQ_MASK_OFS, 32'h0000_0000);
      chk("irq_masked", {31'h0, IRQ}, 32'h0000_0000);
      apb(1'b1, `ADCRC_IRQ_STAT_OFS, 32'h0000_0003);
      apb(1'b1, `ADCRC_IRQ_MASK_OFS, 32'h0000_0001);
      chk("irq_clear", {31'h0, IRQ}, 32'h0000_0000);
      chk("runs", 32'(runs - r0), r.mode[1] ? 2 : 1);
      chk("settle", 32'(settle - s0), r.mode[1] ? 42 : 0);
    end
  endtask : conv

  // ==========================================================
  // main sequence
  initial begin
    rows = '{
      '{3'h4, 20'h0_7FFF, 20'h0_0000, 16'hFFFF, 1'b0, 1'b0},
      '{3'h4, 20'h0_0000, 20'h0_0000, 16'h8000, 1'b0, 1'b0},
      '{3'h4, 20'hF_FFFF, 20'h0_0000, 16'h7FFF, 1'b1, 1'b0},
      '{3'h4, 20'hF_8000, 20'h0_0000, 16'h0000, 1'b1, 1'b0},
      '{3'h4, 20'h0_8000, 20'h0_0000, 16'h0000, 1'b0, 1'b1},
      '{3'h4, 20'h0_947B, 20'h0_0000, 16'h147B, 1'b0, 1'b1},
      '{3'h4, 20'hF_7FFF, 20'h0_0000, 16'hFFFF, 1'b1, 1'b1},
      '{3'h4, 20'hF_6B85, 20'h0_0000, 16'hEB85, 1'b1, 1'b1},
      '{3'h0, 20'h0_FFFF, 20'h0_0000, 16'hFFFF, 1'b0, 1'b0},
      '{3'h0, 20'h0_0000, 20'h0_0000, 16'h0000, 1'b0, 1'b0},
      '{3'h0, 20'h1_0000, 20'h0_0000, 16'h0000, 1'b0, 1'b1},
      '{3'h0, 20'h1_28F5, 20'h0_0000, 16'h28F5, 1'b0, 1'b1},
      '{3'h0, 20'hF_FFFF, 20'h0_0000, 16'h0000, 1'b1, 1'b1},
      '{3'h5, 20'h0_947B, 20'h0_0000, 16'hFFFF, 1'b0, 1'b1},
      '{3'h5, 20'hF_6B85, 20'h0_0000, 16'h0000, 1'b1, 1'b1},
      '{3'h1, 20'h1_28F5, 20'h0_0000, 16'hFFFF, 1'b0, 1'b1},
      '{3'h1, 20'hF_FFFF, 20'h0_0000, 16'h0000, 1'b1, 1'b1},
      '{3'h6, 20'h0_0065, 20'hF_FF9C, 16'h8064, 1'b0, 1'b0},
      '{3'h6, 20'hF_FF9B, 20'h0_0064, 16'h7F9B, 1'b1, 1'b0},
      '{3'h2, 20'h0_03E8, 20'hF_FC18, 16'h03E8, 1'b0, 1'b0}};
    repeat (10) @(posedge CLK);
    RST_B <= 1'b1;
    for (int a = 0; a <= 16; a += 4) begin
      apb(1'b0, 8'(a), 32'h0000_0000);
      chk("reset_reg", rdata, 32'h0000_0000);
      chk("slverr_ok", {31'h0, rerr}, 32'h0000_0000);
    end
    for (int i = 0; i < 20; i++) conv(rows[i], 4'(3 * (i % 4)));
    // unmapped address is refused
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("slverr", {31'h0, rerr}, 32'h0000_0001);
    chk("unmapped", rdata, 32'h0000_0000);
    // second start while busy is ignored; mode bits apply at load
    apb(1'b1, `ADCRC_CTRL_OFS, 32'h0000_0008);
    conv('{3'h4, 20'hF_FFFF, 20'h0_0000, 16'h7FFF, 1'b1, 1'b0}, 4'h2);
    // writes with the clock enable low are lost
    @(posedge CLK);
    CE <= 1'b0;
    apb(1'b1, `ADCRC_IRQ_MASK_OFS, 32'h0000_0000);
    @(posedge CLK);
    CE <= 1'b1;
    apb(1'b0, `ADCRC_IRQ_MASK_OFS, 32'h0000_0000);
    chk("ce_low", rdata, 32'h0000_0001);
    // reset early in the reversed second settle phase, a few cycles after it begins
    apb(1'b1, `ADCRC_CTRL_OFS, 32'h0000_000E);
    repeat (50) @(posedge CLK);
    RST_B <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    #1;
    chk("run_rst", {30'h0, MOD_RUN, CHOP_REVERSE}, 32'h0000_0000);
    apb(1'b0, `ADCRC_CHSTAT_OFS, 32'h0000_0000);
    chk("stat_rst", rdata, 32'h0000_0000);
    report_and_stop();
  end
endmodule : adc_result_range_coding_bench
